/* File: pkg/mds_pkg.sv */
// Constants, register map and types for the multi-device sync sequencer
package mds_pkg;
    // Register word width; registers sit in the low bits of the bus word
    localparam int REG_W = 16;
    localparam int ADR_W = 8;
    localparam int IDX_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_MAIN = 6'h00;
    localparam logic [IDX_W-1:0] IDX_ALARM = 6'h05;
    localparam logic [IDX_W-1:0] IDX_PLL = 6'h18;
    localparam logic [IDX_W-1:0] IDX_FUSE = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_INSYNC = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_SRCSEL = 6'h20;

    // Reset values
    localparam logic [REG_W-1:0] MAIN_RESET = 16'h0000;
    localparam logic [REG_W-1:0] PLL_RESET = 16'h0000;
    localparam logic [REG_W-1:0] FUSE_RESET = 16'h0000;
    localparam logic [REG_W-1:0] INSYNC_RESET = 16'h0000;
    localparam logic [REG_W-1:0] SRCSEL_RESET = 16'h0000;
    localparam logic [REG_W-1:0] ALARM_RESET = 16'h0000;

    // Field positions
    localparam int MAIN_DIVSYNC_EN_BIT = 2;
    localparam int PLL_NDIVSYNC_EN_BIT = 11;
    localparam int PLL_ENABLE_BIT = 14;
    localparam int FUSE_SLEEP_BIT = 11;
    localparam int INSYNC_SEL_LSB = 2;
    localparam int SRC_FIFOIN_LSB = 12;
    localparam int SRC_FIFOOUT_LSB = 8;
    localparam int SRC_DIVSEL_BIT = 0;
    localparam int SEL_W = 4;

    // FIFO input pointer sync source mask bits
    localparam int FIN_INSYNC_BIT = 0;
    localparam int FIN_RSTROBE_BIT = 1;
    // FIFO output pointer sync source mask bits
    localparam int FOUT_HANDOFF_BIT = 0;
    localparam int FOUT_RSTROBE_BIT = 1;

    // Alarm status bits, sticky, write one to clear
    localparam int ALM_COLLISION_BIT = 0;
    localparam int ALM_WR_SYNC_BIT = 1;
    localparam int ALM_RD_SYNC_BIT = 2;
    localparam int ALM_DIV_SYNC_BIT = 3;
    localparam int ALM_NDIV_SYNC_BIT = 4;

    // Pointer, divider and N-divider geometry
    localparam int PTR_W = 3;
    localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
    localparam logic [PTR_W-1:0] FIFO_OFFSET = 3'h4;
    localparam logic [PTR_W-1:0] PTR_STEP = 3'h1;
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
    localparam logic [DIV_W-1:0] DIV_STEP = 2'h1;
    localparam int NDIV_W = 4;
    localparam logic [NDIV_W-1:0] NDIV_ZERO = 4'h0;
    localparam logic [NDIV_W-1:0] NDIV_STEP = 4'h1;
    localparam logic [NDIV_W-1:0] NDIV_LAST = 4'hf;

    // Number of external pins passed through the synchroniser
    localparam int PIN_N = 3;
    localparam int PIN_RSTROBE = 0;
    localparam int PIN_WSTROBE = 1;
    localparam int PIN_AUX = 2;

    typedef enum logic [1:0]
    {
        INSEL_WSTROBE = 2'b00,
        INSEL_AUX = 2'b01,
        INSEL_EITHER = 2'b10,
        INSEL_NONE = 2'b11
    } mds_insel_t;

    typedef enum logic
    {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } mds_bus_t;
endpackage

/* File: rtl/mds_pin_sync.sv */
// Two-flop synchroniser with rising-edge detection for pin inputs
`timescale 1ns/1ps
module mds_pin_sync
    import mds_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
        logic [W-1:0] last;
    } mds_sync_state_t;

    mds_sync_state_t state;
    mds_sync_state_t next_state;

    always_comb
    begin
        next_state = state;
        next_state.meta = pin;
        // First stage is read only by the second stage
        next_state.stable = state.meta;
        next_state.last = state.stable;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.stable;
    assign rise = state.stable & ~state.last;
endmodule

/* File: rtl/mds_sequencer.sv */
// Multi-device sync sequencer: FIFO pointer, divider and N-divider alignment
`timescale 1ns/1ps
module mds_sequencer
    import mds_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic READ_SIDE_STROBE,
    input wire logic WRITE_SIDE_STROBE,
    input wire logic AUX_SYNC,
    input wire logic TRANSMIT_ENABLE_PIN,
    output logic ALARM,
    output logic FUSE_SLEEP,
    output logic TRANSMIT_ACTIVE,
    output logic [PTR_W-1:0] WRITE_POINTER,
    output logic [PTR_W-1:0] READ_POINTER,
    output logic [DIV_W-1:0] DIVIDER_PHASE,
    output logic [NDIV_W-1:0] NDIV_PHASE
);
    typedef struct packed
    {
        mds_bus_t bus;
        logic [31:0] rdata;
        logic [REG_W-1:0] main_control_reg;
        logic [REG_W-1:0] alarm_status_reg;
        logic [REG_W-1:0] pll_control_reg;
        logic [REG_W-1:0] reference_fuse_reg;
        logic [REG_W-1:0] input_sync_reg;
        logic [REG_W-1:0] sync_source_reg;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [DIV_W-1:0] div;
        logic [NDIV_W-1:0] ndiv;
        logic handoff_meta;
        logic handoff_stable;
        logic alarm;
        logic tx_active;
    } mds_state_t;

    mds_state_t state;
    mds_state_t next_state;

    logic [PIN_N-1:0] pin_rise;
    logic transmit_enable_pin_meta;
    logic transmit_enable_pin_stable;

    // Merge a 16-bit register with the low byte lanes of a bus write
    function automatic logic [REG_W-1:0] lane_merge(
        input logic [REG_W-1:0] old_value,
        input logic [31:0] data,
        input logic [3:0] sel
    );
        logic [REG_W-1:0] merged;
        merged = old_value;
        if (sel[0])
        begin
            merged[7:0] = data[7:0];
        end
        if (sel[1])
        begin
            merged[15:8] = data[15:8];
        end
        return merged;
    endfunction

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return p + PTR_STEP;
    endfunction

    mds_pin_sync #(
        .W(PIN_N)
    ) u_pin_sync (
        .clock(CLOCK),
        .reset(RESET),
        .pin({AUX_SYNC, WRITE_SIDE_STROBE, READ_SIDE_STROBE}),
        .level(),
        .rise(pin_rise)
    );

    // Transmit enable is a plain level, only synchronised
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            transmit_enable_pin_meta <= 1'b0;
            transmit_enable_pin_stable <= 1'b0;
        end
        else
        begin
            transmit_enable_pin_meta <= TRANSMIT_ENABLE_PIN;
            transmit_enable_pin_stable <= transmit_enable_pin_meta;
        end
    end

    // Decoded controls
    logic pll_enable;
    logic ndiv_sync_en;
    logic div_sync_en;
    logic div_sel_rstrobe;
    logic [SEL_W-1:0] fifoin_sel;
    logic [SEL_W-1:0] fifoout_sel;
    mds_insel_t insync_sel;
    logic in_sync;
    logic rd_strobe;
    logic ndiv_wrap;
    logic wr_reset;
    logic rd_reset;
    logic div_reset;
    logic ndiv_reset;
    logic collision;
    logic bus_req;
    logic bus_write;
    logic [IDX_W-1:0] bus_idx;

    always_comb
    begin
        pll_enable = state.pll_control_reg[PLL_ENABLE_BIT];
        ndiv_sync_en = state.pll_control_reg[PLL_NDIVSYNC_EN_BIT];
        div_sync_en = state.main_control_reg[MAIN_DIVSYNC_EN_BIT];
        div_sel_rstrobe = state.sync_source_reg[SRC_DIVSEL_BIT];
        fifoin_sel = state.sync_source_reg[SRC_FIFOIN_LSB +: SEL_W];
        fifoout_sel = state.sync_source_reg[SRC_FIFOOUT_LSB +: SEL_W];
        insync_sel = mds_insel_t'(state.input_sync_reg[INSYNC_SEL_LSB +: 2]);

        // FIFO input sync event: write strobe, aux sync or both
        case (insync_sel)
            INSEL_WSTROBE: in_sync = pin_rise[PIN_WSTROBE];
            INSEL_AUX: in_sync = pin_rise[PIN_AUX];
            INSEL_EITHER: in_sync = pin_rise[PIN_WSTROBE] | pin_rise[PIN_AUX];
            default: in_sync = 1'b0;
        endcase

        // N-divider wrap acts as internal read strobe with the PLL on
        ndiv_wrap = (state.ndiv == NDIV_LAST);
        // Both strobe paths sampled on the conversion clock
        rd_strobe = pll_enable ? ndiv_wrap : pin_rise[PIN_RSTROBE];

        // Aux sync edges reach the N divider only while enabled
        ndiv_reset = pll_enable & ndiv_sync_en & pin_rise[PIN_AUX];

        wr_reset = (fifoin_sel[FIN_INSYNC_BIT] & in_sync)
            | (fifoin_sel[FIN_RSTROBE_BIT] & rd_strobe);

        // Dual mode follows the strobe; single mode the resampled write reset
        rd_reset = (fifoout_sel[FOUT_RSTROBE_BIT] & rd_strobe)
            | (fifoout_sel[FOUT_HANDOFF_BIT] & state.handoff_stable);

        // Divider sync is gated by its enable; periodic strobes just realign
        div_reset = div_sync_en & (div_sel_rstrobe ? rd_strobe : in_sync);

        collision = (state.wr_ptr == state.rd_ptr);

        bus_req = WB_CYC_I & WB_STB_I;
        bus_write = bus_req & WB_WE_I & (state.bus == BUS_ACK);
        bus_idx = WB_ADR_I[ADR_W-1:2];
    end

    always_comb
    begin
        next_state = state;

        // Classic Wishbone: one wait state, write lands on the ack edge
        case (state.bus)
            BUS_IDLE:
            begin
                if (bus_req)
                begin
                    next_state.bus = BUS_ACK;
                    next_state.rdata = '0;
                    case (bus_idx)
                        IDX_MAIN: next_state.rdata[REG_W-1:0] = state.main_control_reg;
                        IDX_ALARM: next_state.rdata[REG_W-1:0] = state.alarm_status_reg;
                        IDX_PLL: next_state.rdata[REG_W-1:0] = state.pll_control_reg;
                        IDX_FUSE: next_state.rdata[REG_W-1:0] = state.reference_fuse_reg;
                        IDX_INSYNC: next_state.rdata[REG_W-1:0] = state.input_sync_reg;
                        IDX_SRCSEL: next_state.rdata[REG_W-1:0] = state.sync_source_reg;
                        default: next_state.rdata = '0;
                    endcase
                end
            end
            BUS_ACK:
            begin
                next_state.bus = BUS_IDLE;
            end
            default:
            begin
                next_state.bus = BUS_IDLE;
            end
        endcase

        if (bus_write)
        begin
            case (bus_idx)
                IDX_MAIN:
                begin
                    next_state.main_control_reg =
                        lane_merge(state.main_control_reg, WB_DAT_I, WB_SEL_I);
                end
                IDX_ALARM:
                begin
                    // Write one to clear; the set below overrides
                    next_state.alarm_status_reg = state.alarm_status_reg
                        & ~lane_merge(16'h0000, WB_DAT_I, WB_SEL_I);
                end
                IDX_PLL:
                begin
                    next_state.pll_control_reg =
                        lane_merge(state.pll_control_reg, WB_DAT_I, WB_SEL_I);
                end
                IDX_FUSE:
                begin
                    next_state.reference_fuse_reg =
                        lane_merge(state.reference_fuse_reg, WB_DAT_I, WB_SEL_I);
                end
                IDX_INSYNC:
                begin
                    next_state.input_sync_reg =
                        lane_merge(state.input_sync_reg, WB_DAT_I, WB_SEL_I);
                end
                IDX_SRCSEL:
                begin
                    next_state.sync_source_reg =
                        lane_merge(state.sync_source_reg, WB_DAT_I, WB_SEL_I);
                end
                default:
                begin
                    next_state.rdata = state.rdata;
                end
            endcase
        end

        // Write-pointer reset handed to the read side through two stages
        next_state.handoff_meta = wr_reset & fifoout_sel[FOUT_HANDOFF_BIT];
        next_state.handoff_stable = state.handoff_meta;

        // Pointers free-run; counting needs no clock other than this one
        if (wr_reset)
        begin
            next_state.wr_ptr = PTR_ZERO;
        end
        else
        begin
            next_state.wr_ptr = ptr_inc(state.wr_ptr);
        end

        if (rd_reset)
        begin
            // Read pointer trails write pointer by the FIFO offset
            next_state.rd_ptr = PTR_ZERO - FIFO_OFFSET;
        end
        else
        begin
            next_state.rd_ptr = ptr_inc(state.rd_ptr);
        end

        if (div_reset)
        begin
            next_state.div = DIV_ZERO;
        end
        else
        begin
            next_state.div = state.div + DIV_STEP;
        end

        // N divider needs no relation to the write strobe or data clock
        if (ndiv_reset || !pll_enable)
        begin
            next_state.ndiv = NDIV_ZERO;
        end
        else
        begin
            next_state.ndiv = state.ndiv + NDIV_STEP;
        end

        // Sticky status; a hardware set wins over a same-cycle clear
        if (collision)
        begin
            next_state.alarm_status_reg[ALM_COLLISION_BIT] = 1'b1;
        end
        if (wr_reset)
        begin
            next_state.alarm_status_reg[ALM_WR_SYNC_BIT] = 1'b1;
        end
        if (rd_reset)
        begin
            next_state.alarm_status_reg[ALM_RD_SYNC_BIT] = 1'b1;
        end
        if (div_reset)
        begin
            next_state.alarm_status_reg[ALM_DIV_SYNC_BIT] = 1'b1;
        end
        if (ndiv_reset)
        begin
            next_state.alarm_status_reg[ALM_NDIV_SYNC_BIT] = 1'b1;
        end

        // Alarm pin mirrors the sticky collision bit
        next_state.alarm = next_state.alarm_status_reg[ALM_COLLISION_BIT];

        // Transmit stays off while a collision is pending, forcing resync
        next_state.tx_active = transmit_enable_pin_stable
            & ~next_state.alarm_status_reg[ALM_COLLISION_BIT];
    end

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            state.bus <= BUS_IDLE;
            state.rdata <= '0;
            state.main_control_reg <= MAIN_RESET;
            state.alarm_status_reg <= ALARM_RESET;
            state.pll_control_reg <= PLL_RESET;
            state.reference_fuse_reg <= FUSE_RESET;
            state.input_sync_reg <= INSYNC_RESET;
            state.sync_source_reg <= SRCSEL_RESET;
            state.wr_ptr <= PTR_ZERO;
            state.rd_ptr <= PTR_ZERO;
            state.div <= DIV_ZERO;
            state.ndiv <= NDIV_ZERO;
            state.handoff_meta <= 1'b0;
            state.handoff_stable <= 1'b0;
            state.alarm <= 1'b0;
            state.tx_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign WB_ACK_O = (state.bus == BUS_ACK);
    assign WB_DAT_O = state.rdata;
    assign ALARM = state.alarm;
    assign FUSE_SLEEP = state.reference_fuse_reg[FUSE_SLEEP_BIT];
    assign TRANSMIT_ACTIVE = state.tx_active;
    assign WRITE_POINTER = state.wr_ptr;
    assign READ_POINTER = state.rd_ptr;
    assign DIVIDER_PHASE = state.div;
    assign NDIV_PHASE = state.ndiv;
endmodule

/* File: tb/mds_sequencer_chk.sv */
// Port-level assertions for the multi-device sync sequencer
`timescale 1ns/1ps
module mds_sequencer_chk
    import mds_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic TRANSMIT_ENABLE_PIN,
    input wire logic ALARM,
    input wire logic TRANSMIT_ACTIVE,
    input wire logic [PTR_W-1:0] WRITE_POINTER,
    input wire logic [PTR_W-1:0] READ_POINTER,
    input wire logic [DIV_W-1:0] DIVIDER_PHASE,
    input wire logic [NDIV_W-1:0] NDIV_PHASE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence

    property p_ack;
        s_req |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_hi;
        WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000;
    endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
    property p_wp_step;
        (WRITE_POINTER == $past(WRITE_POINTER) + PTR_STEP) || (WRITE_POINTER == PTR_ZERO);
    endproperty
    a_wp_step: assert property (p_wp_step) else $error("write pointer jump");
    property p_rp_step;
        // Reset value differs from the sync value, so skip the edge after release
        !$past(RESET) |-> (READ_POINTER == $past(READ_POINTER) + PTR_STEP)
            || (READ_POINTER == FIFO_OFFSET);
    endproperty
    a_rp_step: assert property (p_rp_step) else $error("read pointer jump");
    property p_div_step;
        (DIVIDER_PHASE == $past(DIVIDER_PHASE) + DIV_STEP) || (DIVIDER_PHASE == DIV_ZERO);
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider jump");
    property p_ndiv_step;
        (NDIV_PHASE == $past(NDIV_PHASE) + NDIV_STEP) || (NDIV_PHASE == NDIV_ZERO);
    endproperty
    a_ndiv_step: assert property (p_ndiv_step) else $error("n-divider jump");
    property p_collide;
        (WRITE_POINTER == READ_POINTER) |-> ##[1:2] ALARM;
    endproperty
    a_collide: assert property (p_collide) else $error("collision not flagged");
    property p_alarm_tx;
        ALARM |-> !TRANSMIT_ACTIVE;
    endproperty
    a_alarm_tx: assert property (p_alarm_tx) else $error("transmit during alarm");
    property p_tx_off;
        !TRANSMIT_ENABLE_PIN [*4] |-> !TRANSMIT_ACTIVE;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmit without enable");
endmodule
bind mds_sequencer mds_sequencer_chk u_chk (.CLOCK(CLOCK), .RESET(RESET),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .TRANSMIT_ENABLE_PIN(TRANSMIT_ENABLE_PIN), .ALARM(ALARM),
    .TRANSMIT_ACTIVE(TRANSMIT_ACTIVE), .WRITE_POINTER(WRITE_POINTER),
    .READ_POINTER(READ_POINTER), .DIVIDER_PHASE(DIVIDER_PHASE), .NDIV_PHASE(NDIV_PHASE));

/* File: tb/mds_far_end.sv */
// Far-side model: clock distributor strobe and baseband sync pulses
`timescale 1ns/1ps
module mds_far_end
    import mds_pkg::*;
(
    input wire logic clock,
    input wire logic [PIN_N-1:0] fire,
    output logic [PIN_N-1:0] pins
);
    logic [PIN_N-1:0][2:0] hold = '0;
    // Launched from the conversion clock; 4 cycles beats the 2-cycle minimum
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            if (fire[i])
                hold[i] <= 3'h4;
            else if (hold[i] != 3'h0)
                hold[i] <= hold[i] - 3'h1;
        end
    end
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
            pins[i] = (hold[i] != 3'h0);
    end
endmodule

/* File: tb/mds_sequencer_tb.sv */
// Self-checking bench for the multi-device sync sequencer
`timescale 1ns/1ps
module mds_sequencer_tb
    import mds_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = '0;
    logic [31:0] wb_dat = '0;
    logic tx_pin = 1'b0;
    logic [PIN_N-1:0] fire = '0;
    logic [PIN_N-1:0] pins;
    logic [31:0] rd_dat;
    logic wb_ack, alarm, fuse_sleep, tx_active;
    logic [PTR_W-1:0] wp, rp;
    logic [DIV_W-1:0] div;
    logic [NDIV_W-1:0] ndiv, nd0;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic [IDX_W-1:0] rw_idx[5] = '{IDX_MAIN, IDX_PLL, IDX_FUSE, IDX_INSYNC, IDX_SRCSEL};
    logic [15:0] r;
    int num_errors = 0;
    int check_count = 0;
    int seed = 32'h46df;

    initial
    begin
        forever #2 clock = ~clock;
    end

    mds_sequencer uut (.CLOCK(clock), .RESET(reset), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
        .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat),
        .WB_DAT_O(rd_dat), .WB_ACK_O(wb_ack), .READ_SIDE_STROBE(pins[PIN_RSTROBE]),
        .WRITE_SIDE_STROBE(pins[PIN_WSTROBE]), .AUX_SYNC(pins[PIN_AUX]),
        .TRANSMIT_ENABLE_PIN(tx_pin), .ALARM(alarm), .FUSE_SLEEP(fuse_sleep),
        .TRANSMIT_ACTIVE(tx_active), .WRITE_POINTER(wp), .READ_POINTER(rp),
        .DIVIDER_PHASE(div), .NDIV_PHASE(ndiv));
    mds_far_end far (.clock(clock), .fire(fire), .pins(pins));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // For reads d is the expected value, compared under mask m
    task automatic wb(input logic w, input logic [IDX_W-1:0] idx, input logic [15:0] d,
        input logic [3:0] s = 4'hf, input logic [15:0] m = 16'hffff);
        int n;
        if (!w)
        begin
            exp_q.push_back({16'h0000, d});
            mask_q.push_back({16'hffff, m});
        end
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_sel <= s;
        wb_dat <= {16'h0000, d};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20)
        begin
            num_errors++;
            final_report();
        end
    endtask

    always @(posedge clock)
    begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
        begin
            check("read_data", rd_dat & mask_q[0], exp_q[0] & mask_q[0]);
            void'(mask_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    task automatic at(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Returns 1 ns after the edge at which the pin rises
    task automatic pulse(input int p);
        @(posedge clock);
        fire[p] <= 1'b1;
        @(posedge clock);
        fire[p] <= 1'b0;
        #1;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        wb(0, IDX_ALARM, 16'h0001);
        wb(1, 6'h01, 16'h5a5a);
        wb(0, 6'h01, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            r = 16'($random(seed));
            wb(0, rw_idx[i], 16'h0000);
            wb(1, rw_idx[i], r);
            wb(0, rw_idx[i], r);
            wb(1, rw_idx[i], 16'h0000);
        end
        wb(1, IDX_FUSE, 16'hffff, 4'h1);
        wb(0, IDX_FUSE, 16'h00ff);
        at(2);
        check("fuse_sleep", fuse_sleep, 1'b0);
        wb(1, IDX_FUSE, 16'h0800);
        at(2);
        check("fuse_sleep", fuse_sleep, 1'b1);
        // Single source: aux resets both pointers and divider
        wb(1, IDX_INSYNC, 16'h0004);
        wb(1, IDX_SRCSEL, 16'h1100);
        wb(1, IDX_MAIN, 16'h0004);
        // Edge seen two edges after the pin rises, reset lands on the third
        pulse(PIN_AUX);
        at(3);
        check("wp_reset", wp, PTR_ZERO);
        check("div_reset", div, DIV_ZERO);
        at(2);
        check("rp_handoff", rp, FIFO_OFFSET);
        check("alarm_pin", alarm, 1'b1);
        wb(0, IDX_ALARM, 16'h000b, 4'hf, 16'h000b);
        wb(1, IDX_ALARM, 16'h001f);
        wb(0, IDX_ALARM, 16'h0000);
        wb(1, IDX_MAIN, 16'h0000);
        wb(1, IDX_SRCSEL, 16'h0000);
        tx_pin <= 1'b1;
        pulse(PIN_AUX);
        at(8);
        check("div_gated", div, wp[1:0]);
        check("rp_kept", 3'(rp - wp), 3'h2);
        check("tx_active", tx_active, 1'b1);
        // Dual source: read strobe aligns read pointer and divider, twice
        wb(1, IDX_INSYNC, 16'h000c);
        wb(1, IDX_SRCSEL, 16'h0201);
        wb(1, IDX_MAIN, 16'h0004);
        for (int k = 0; k < 2; k++)
        begin
            pulse(PIN_RSTROBE);
            at(3);
            check("rp_strobe", rp, FIFO_OFFSET);
            check("div_strobe", div, DIV_ZERO);
            at(3);
        end
        wb(1, IDX_MAIN, 16'h0000);
        // PLL: aux resets N divider only when its enable is set
        wb(1, IDX_SRCSEL, 16'h0000);
        wb(1, IDX_INSYNC, 16'h0004);
        wb(1, IDX_PLL, 16'h4800);
        pulse(PIN_AUX);
        at(3);
        check("ndiv_reset", ndiv, NDIV_ZERO);
        wb(1, IDX_PLL, 16'h4000);
        pulse(PIN_AUX);
        nd0 = ndiv;
        at(4);
        check("ndiv_gated", ndiv, 4'(nd0 + 4'h4));
        wb(1, IDX_PLL, 16'h0000);
        at(2);
        check("ndiv_off", ndiv, NDIV_ZERO);
        check("reads_left", exp_q.size(), 0);
        final_report();
    end
endmodule
